// File: hw/ips_pkg.sv
// Shared constants, carriers and state encoding of the interleaved PFC sequencer.
package ips_pkg;

  // Clock and timing, each time in its own unit with the derived count beside it.
  localparam int CLK_NS          = 25;
  localparam int SW_FREQ_KHZ     = 100;
  localparam int SW_PERIOD_CYC   = 1000000 / (SW_FREQ_KHZ * CLK_NS);
  localparam int SET_PULSE_NS    = 100;
  localparam int SET_PULSE_CYC   = (SET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BRIDGE_TON_US   = 20;
  localparam int BRIDGE_TON_CYC  = (BRIDGE_TON_US * 1000) / CLK_NS;
  localparam int STEP_SHIFT_US   = 5;
  localparam int STEP_SHIFT_CYC  = (STEP_SHIFT_US * 1000) / CLK_NS;
  localparam int INRUSH_MS       = 500;
  localparam int INRUSH_CYC      = INRUSH_MS * (1000000 / CLK_NS);
  localparam int GAP_MS          = 10;
  localparam int GAP_CYC         = GAP_MS * (1000000 / CLK_NS);

  // Data path widths and loop gains (shift amounts).
  localparam int MEAS_W     = 12;
  localparam int LINE_W     = 20;
  localparam int RMS_WIN_SH = 8;
  localparam int KP_SH      = 2;
  localparam int KI_SH      = 6;
  localparam int LOAD_SH    = 2;
  localparam logic [MEAS_W-1:0] SOFT_REF = 12'h400;

  // Half-sine table, sixteen points over one line half cycle.
  localparam logic [7:0] SINE_LUT [16] = '{8'h19, 8'h4a, 8'h78, 8'ha2, 8'hc5, 8'he1,
    8'hf4, 8'hfe, 8'hfe, 8'hf4, 8'he1, 8'hc5, 8'ha2, 8'h78, 8'h4a, 8'h19};

  // Bit positions of the pin inputs in the synchroniser bank.
  localparam int PIN_START = 0;
  localparam int PIN_EN    = 1;
  localparam int PIN_SYNC  = 2;
  localparam int PIN_PSET  = 3;
  localparam int PIN_LINE  = 4;
  localparam int PIN_DA    = 5;
  localparam int PIN_DB    = 6;
  localparam int PIN_SWOC  = 7;
  localparam int PIN_INOC  = 8;
  localparam int PIN_W     = 9;

  typedef struct packed {
    logic [MEAS_W-1:0] lineA;
    logic [MEAS_W-1:0] lineB;
    logic [MEAS_W-1:0] temp;
    logic [MEAS_W-1:0] iout;
    logic [MEAS_W-1:0] vout;
    logic [MEAS_W-1:0] ich0;
    logic [MEAS_W-1:0] ich1;
  } ips_meas_t;

  typedef struct packed {
    logic [MEAS_W-1:0]   voutRef;
    logic [MEAS_W-1:0]   burstMin;
    logic [MEAS_W-1:0]   burstMax;
    logic [MEAS_W-1:0]   ovpLevel;
    logic [MEAS_W-1:0]   tempLimit;
    logic [MEAS_W-1:0]   loadDetect;
    logic [MEAS_W-1:0]   halfLoad;
    logic [2*MEAS_W-1:0] fanPower;
  } ips_cfg_t;

  typedef enum logic [2:0] {ST_IDLE, ST_INRUSH, ST_GAP, ST_SOFT, ST_BURST, ST_RUN} ips_state_t;

endpackage

// File: hw/ips_sync.sv
// Two flip-flop synchroniser bank for the pin inputs.
`timescale 1ns/1ps
module ips_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  if (WIDTH < 1) begin : g_chk
    $error("ips_sync needs at least one bit");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_ff;
    logic sync_ff;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_ff <= 1'b0;
        sync_ff <= 1'b0;
      end else begin
        meta_ff <= din[i];
        sync_ff <= meta_ff;
      end
    end
    assign dout[i] = sync_ff;
  end

endmodule

// File: hw/ips_sequencer.sv
// Drive generation, protection and start-up sequencing of the interleaved PFC.
//
// What this block does
// - Emit switching square wave; drive only while looped-back enable wave runs.
// - Make slave set pulse half a master period after master rising edge.
// - Set pulse leaves on phaseSetOut, loops back; flop sets slave drive.
// - Master drive duty ends when either duty comparator drops.
// - Switch overcurrent stops both channel drives; input overcurrent is also sensed.
// - Thermal sense below limit stops switching.
// - Subtract both line samples and compute RMS line voltage.
// - RMS line changes adjust voltage loop output directly.
// - Output current scales the current reference up.
// - Slave channel enabled above half-load output current, and always during soft power-on.
// - Output voltage feeds regulation and overvoltage shutdown.
// - Channel current difference gives a balance trim.
// - Inrush for set time, short gap, then soft power-on.
// - Bridge switches fired alternately by polarity near half-cycle end.
// - Each firing advances by a fixed step until full conduction.
// - Soft power-on holds constant reference with both channels active.
// - Power-good goes low once output reaches setpoint.
// - Without load, burst between lower and upper levels.
// - Load detected leaves burst and regulates at setpoint.
// - Cooling request low while output power exceeds threshold.
// - Fault indicator low while a fault is present.
// - Overcurrent indicator low on either overcurrent comparator.
// - Falling edge of looped master drive clears slave drive.
// - Rising edge of zero-cross input restarts the sine table.
`timescale 1ns/1ps
module ips_sequencer
  import ips_pkg::*;
#(
  parameter int INRUSH_CYCLES = INRUSH_CYC,
  parameter int GAP_CYCLES    = GAP_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Pins from the board and power stage
  input  wire logic              startReq,
  input  wire logic              enableIn,
  input  wire logic              syncInput,
  input  wire logic              phaseSetIn,
  input  wire logic              lineZeroCross,
  input  wire logic              dutyComparatorA,
  input  wire logic              dutyComparatorB,
  input  wire logic              switchOvercurrentComparator,
  input  wire logic              inputOvercurrentComparator,
  // Measurements and configuration
  input  wire ips_meas_t         meas,
  input  wire logic              measValid,
  input  wire ips_cfg_t          cfg,
  // Drives
  output logic                   switchClk,
  output logic                   masterChannelDrive,
  output logic                   phaseSetOut,
  output logic                   slaveChannelDrive,
  output logic                   bridgeSwitchA,
  output logic                   bridgeSwitchB,
  // Indicators and internal results
  output logic                   powerGoodN,
  output logic                   faultIndicatorN,
  output logic                   overcurrentIndicatorN,
  output logic                   coolingReqN,
  output logic [MEAS_W-1:0]      currentRef,
  output logic [MEAS_W-1:0]      rmsLineVoltage,
  output logic signed [MEAS_W:0] balanceTrim
);

  localparam int SWC_W = $clog2(SW_PERIOD_CYC);
  localparam logic [SWC_W:0] EN_AGE_MAX = (SWC_W+1)'(2 * SW_PERIOD_CYC);

  if (INRUSH_CYCLES < 1 || GAP_CYCLES < 1 || SW_PERIOD_CYC < 4) begin : g_chk
    $error("ips_sequencer timing parameters out of range");
  end

  // Pin synchronisation and edges.
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinS;
  logic [PIN_W-1:0] pinPrev_ff;
  assign pinRaw = {inputOvercurrentComparator, switchOvercurrentComparator, dutyComparatorB,
                   dutyComparatorA, lineZeroCross, phaseSetIn, syncInput, enableIn, startReq};

  ips_sync #(.WIDTH(PIN_W)) uSync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (pinRaw),
    .dout  (pinS)
  );

  wire enRise   = pinS[PIN_EN] & ~pinPrev_ff[PIN_EN];
  wire syncRise = pinS[PIN_SYNC] & ~pinPrev_ff[PIN_SYNC];
  wire syncFall = ~pinS[PIN_SYNC] & pinPrev_ff[PIN_SYNC];
  wire psRise   = pinS[PIN_PSET] & ~pinPrev_ff[PIN_PSET];
  wire lineRise = pinS[PIN_LINE] & ~pinPrev_ff[PIN_LINE];
  wire lineEdge = pinS[PIN_LINE] ^ pinPrev_ff[PIN_LINE];

  // Registers.
  ips_state_t               state_ff, nxt_state;
  logic [31:0]              stateCnt_ff;
  ips_meas_t                measLat_ff;
  logic                     burstOn_ff, master_ff, slave_ff, swClk_ff;
  logic [SWC_W-1:0]         swCnt_ff;
  logic [SWC_W:0]           enAge_ff;
  logic [15:0]              perCnt_ff, halfPer_ff;
  logic                     phaseArm_ff, phaseSet_ff;
  logic [3:0]               psCnt_ff;
  logic [LINE_W-1:0]        lineCnt_ff, halfLine_ff, advance_ff, brCnt_ff, stepCnt_ff;
  logic                     brPol_ff, brA_ff, brB_ff;
  logic [LINE_W-1:0]        rmsAcc_ff;
  logic [RMS_WIN_SH-1:0]    winCnt_ff;
  logic [MEAS_W-1:0]        rms_ff, rmsPrev_ff, ipk_ff, curRef_ff;
  logic signed [LINE_W-1:0] integ_ff;
  logic [3:0]               lutIdx_ff;
  logic signed [MEAS_W:0]   trim_ff;
  logic                     pgN_ff, faultN_ff, ocN_ff, fanN_ff;

  // Protection: overvoltage, thermal and switch overcurrent stop both channel drives.
  wire ovp      = measLat_ff.vout > cfg.ovpLevel;
  wire hot      = measLat_ff.temp < cfg.tempLimit;
  wire shutdown = ovp | hot | pinS[PIN_SWOC];
  wire anyOc    = pinS[PIN_SWOC] | pinS[PIN_INOC];

  // Drive permission by phase of the start-up sequence.
  wire stagedRun = (state_ff == ST_SOFT) || (state_ff == ST_RUN) ||
                   (state_ff == ST_BURST && burstOn_ff);
  // The enable wave counts as present while its rising edges keep arriving. Gating on its
  // level instead would block every drive in the low half, so no slave pulse could start.
  wire enPresent    = enRise | (enAge_ff < EN_AGE_MAX);
  wire runAllowed   = enPresent & ~shutdown & stagedRun;
  wire slaveAllowed = (state_ff == ST_SOFT) ||
                      (measLat_ff.iout > cfg.halfLoad);

  // Master turns on at each switching period start; either comparator ends it.
  wire nxt_master = runAllowed &
                    (enRise | (master_ff & pinS[PIN_DA] & pinS[PIN_DB]));
  // Slave is set by the looped set pulse and cleared by the master's falling edge.
  wire nxt_slave  = runAllowed & slaveAllowed & ~syncFall & (psRise | slave_ff);

  // Switching clock divider, high for the first half of the period.
  wire swWrap = swCnt_ff == SWC_W'(SW_PERIOD_CYC - 1);
  wire [SWC_W-1:0] nxt_swCnt = swWrap ? '0 : swCnt_ff + 1'b1;
  wire nxt_swClk = nxt_swCnt < SWC_W'(SW_PERIOD_CYC / 2);

  // Set generator: half of the measured master period after its rising edge.
  wire phaseFire = phaseArm_ff & ~syncRise & (perCnt_ff == halfPer_ff);
  wire [3:0] nxt_psCnt = phaseFire ? 4'(SET_PULSE_CYC) :
                         (psCnt_ff != 4'h0) ? psCnt_ff - 4'h1 : 4'h0;

  // Inrush firing point: end of half cycle, moved earlier by the advance.
  localparam logic [LINE_W-1:0] TON_L  = LINE_W'(BRIDGE_TON_CYC);
  localparam logic [LINE_W-1:0] STEP_L = LINE_W'(STEP_SHIFT_CYC);
  wire inInrush  = state_ff == ST_INRUSH;
  wire roomLeft  = halfLine_ff > TON_L + advance_ff;
  wire [LINE_W-1:0] fireAt = roomLeft ? halfLine_ff - TON_L - advance_ff : '0;
  wire brFire    = inInrush & ~lineEdge & (halfLine_ff != '0) &
                   (lineCnt_ff == fireAt);
  wire canStep   = halfLine_ff > TON_L + advance_ff + STEP_L;
  wire [LINE_W-1:0] nxt_brCnt = !inInrush ? '0 : brFire ? TON_L :
                                (brCnt_ff != '0) ? brCnt_ff - 1'b1 : '0;
  wire nxt_brPol = brFire ? pinS[PIN_LINE] : brPol_ff;

  // RMS: mean rectified difference times 1.125 approximates the sine form factor.
  wire signed [MEAS_W:0] lineDiff = $signed({1'b0, meas.lineA}) - $signed({1'b0, meas.lineB});
  wire [MEAS_W-1:0] lineAbs = lineDiff[MEAS_W] ? MEAS_W'(-lineDiff) : lineDiff[MEAS_W-1:0];
  wire [LINE_W-1:0] accNext = rmsAcc_ff + LINE_W'(lineAbs);
  wire [MEAS_W:0] rmsSum = {1'b0, accNext[LINE_W-1:RMS_WIN_SH]} +
                           {4'h0, accNext[LINE_W-1:RMS_WIN_SH+3]};
  wire winEnd = winCnt_ff == '1;

  // Digital voltage loop with line and load feed-forward.
  wire signed [MEAS_W:0] vErr = $signed({1'b0, cfg.voutRef}) - $signed({1'b0, meas.vout});
  wire regulate = (state_ff == ST_BURST) || (state_ff == ST_RUN);
  wire signed [LINE_W-1:0] nxt_integ = regulate ? integ_ff + LINE_W'(vErr) : '0;
  wire signed [LINE_W+1:0] piSum = (LINE_W+2)'(vErr <<< KP_SH) +
                                   (LINE_W+2)'(integ_ff >>> KI_SH) +
                                   (LINE_W+2)'($signed({1'b0, rmsPrev_ff}) -
                                               $signed({1'b0, rms_ff})) +
                                   (LINE_W+2)'({1'b0, meas.iout >> LOAD_SH});
  wire [MEAS_W-1:0] piClamp = piSum[LINE_W+1] ? '0 :
                              (piSum > (LINE_W+2)'(4095)) ? '1 : piSum[MEAS_W-1:0];
  wire [MEAS_W-1:0] nxt_ipk = (state_ff == ST_SOFT) ? SOFT_REF :
                              regulate ? piClamp : '0;

  // Sine table stepping: sixteen entries per measured line half cycle.
  wire stepDone = stepCnt_ff >= (halfLine_ff >> 4);
  wire [19:0] refProd = ipk_ff * SINE_LUT[lutIdx_ff];
  wire [2*MEAS_W-1:0] outPower = measLat_ff.vout * measLat_ff.iout;

  // Start-up sequence.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (pinS[PIN_START]) nxt_state = ST_INRUSH;
      end
      ST_INRUSH: begin
        if (stateCnt_ff >= 32'(INRUSH_CYCLES - 1)) nxt_state = ST_GAP;
      end
      ST_GAP: begin
        if (stateCnt_ff >= 32'(GAP_CYCLES - 1)) nxt_state = ST_SOFT;
      end
      ST_SOFT: begin
        if (measLat_ff.vout >= cfg.voutRef) nxt_state = ST_BURST;
      end
      ST_BURST: begin
        if (measLat_ff.iout > cfg.loadDetect) nxt_state = ST_RUN;
      end
      default: nxt_state = state_ff;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      stateCnt_ff <= '0;
      pinPrev_ff  <= '0;
      measLat_ff  <= '0;
      burstOn_ff  <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      stateCnt_ff <= (nxt_state != state_ff) ? '0 : stateCnt_ff + 1'b1;
      pinPrev_ff  <= pinS;
      if (measValid) measLat_ff <= meas;
      if (measLat_ff.vout < cfg.burstMin) burstOn_ff <= 1'b1;
      else if (measLat_ff.vout > cfg.burstMax) burstOn_ff <= 1'b0;
    end
  end

  // Channel drives and the set generator.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swCnt_ff    <= '0;
      enAge_ff    <= '1;
      swClk_ff    <= 1'b0;
      master_ff   <= 1'b0;
      slave_ff    <= 1'b0;
      perCnt_ff   <= '0;
      halfPer_ff  <= '0;
      phaseArm_ff <= 1'b0;
      psCnt_ff    <= '0;
      phaseSet_ff <= 1'b0;
    end else begin
      swCnt_ff    <= nxt_swCnt;
      enAge_ff    <= enRise ? '0 : enPresent ? enAge_ff + 1'b1 : enAge_ff;
      swClk_ff    <= nxt_swClk;
      master_ff   <= nxt_master;
      slave_ff    <= nxt_slave;
      perCnt_ff   <= syncRise ? '0 : (perCnt_ff != '1) ? perCnt_ff + 1'b1 : perCnt_ff;
      if (syncRise) halfPer_ff <= (perCnt_ff + 16'h1) >> 1;
      phaseArm_ff <= syncRise | (phaseArm_ff & ~phaseFire);
      psCnt_ff    <= nxt_psCnt;
      phaseSet_ff <= nxt_psCnt != 4'h0;
    end
  end

  // Inrush bridge firing.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineCnt_ff  <= '0;
      halfLine_ff <= '0;
      advance_ff  <= '0;
      brCnt_ff    <= '0;
      brPol_ff    <= 1'b0;
      brA_ff      <= 1'b0;
      brB_ff      <= 1'b0;
    end else begin
      lineCnt_ff <= lineEdge ? '0 : (lineCnt_ff != '1) ? lineCnt_ff + 1'b1 : lineCnt_ff;
      if (lineEdge) halfLine_ff <= lineCnt_ff;
      if (!inInrush) advance_ff <= '0;
      else if (lineEdge && canStep) advance_ff <= advance_ff + STEP_L;
      brCnt_ff <= nxt_brCnt;
      brPol_ff <= nxt_brPol;
      brA_ff   <= (nxt_brCnt != '0) & nxt_brPol;
      brB_ff   <= (nxt_brCnt != '0) & ~nxt_brPol;
    end
  end

  // Measurements, voltage loop and reference.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rmsAcc_ff  <= '0;
      winCnt_ff  <= '0;
      rms_ff     <= '0;
      rmsPrev_ff <= '0;
      integ_ff   <= '0;
      ipk_ff     <= '0;
      lutIdx_ff  <= '0;
      stepCnt_ff <= '0;
      curRef_ff  <= '0;
      trim_ff    <= '0;
    end else begin
      if (measValid) begin
        winCnt_ff <= winCnt_ff + 1'b1;
        rmsAcc_ff <= winEnd ? '0 : accNext;
        if (winEnd) begin
          rmsPrev_ff <= rms_ff;
          rms_ff     <= rmsSum[MEAS_W] ? '1 : rmsSum[MEAS_W-1:0];
        end
        integ_ff <= nxt_integ;
        ipk_ff   <= nxt_ipk;
        trim_ff  <= $signed({1'b0, meas.ich0}) - $signed({1'b0, meas.ich1});
      end
      if (lineRise || stepDone) stepCnt_ff <= '0;
      else stepCnt_ff <= stepCnt_ff + 1'b1;
      if (lineRise) lutIdx_ff <= '0;
      else if (stepDone) lutIdx_ff <= lutIdx_ff + 1'b1;
      curRef_ff <= refProd[19:8];
    end
  end

  // Status indicators.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pgN_ff    <= 1'b1;
      faultN_ff <= 1'b1;
      ocN_ff    <= 1'b1;
      fanN_ff   <= 1'b1;
    end else begin
      pgN_ff    <= ~regulate;
      faultN_ff <= ~shutdown;
      ocN_ff    <= ~anyOc;
      fanN_ff   <= ~(outPower > cfg.fanPower);
    end
  end

  assign switchClk             = swClk_ff;
  assign masterChannelDrive    = master_ff;
  assign phaseSetOut           = phaseSet_ff;
  assign slaveChannelDrive     = slave_ff;
  assign bridgeSwitchA         = brA_ff;
  assign bridgeSwitchB         = brB_ff;
  assign powerGoodN            = pgN_ff;
  assign faultIndicatorN       = faultN_ff;
  assign overcurrentIndicatorN = ocN_ff;
  assign coolingReqN           = fanN_ff;
  assign currentRef            = curRef_ff;
  assign rmsLineVoltage        = rms_ff;
  assign balanceTrim           = trim_ff;

  // Checks on the drive and sequencing behaviour.
  property p_enable_gate;
    @(posedge clk) disable iff (!rst_n) !enPresent |=> !master_ff && !slave_ff;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("drive without enable");

  property p_set_pulse;
    @(posedge clk) disable iff (!rst_n) $rose(phaseSet_ff) |-> phaseSet_ff[*4] ##1 !phaseSet_ff;
  endproperty
  a_set_pulse: assert property (p_set_pulse) else $error("set pulse width wrong");

  property p_slave_set;
    @(posedge clk) disable iff (!rst_n) $rose(slave_ff) |-> $past(psRise);
  endproperty
  a_slave_set: assert property (p_slave_set) else $error("slave set without pulse");

  property p_duty_end;
    @(posedge clk) disable iff (!rst_n)
      (!pinS[PIN_DA] || !pinS[PIN_DB]) && !enRise |=> !master_ff;
  endproperty
  a_duty_end: assert property (p_duty_end) else $error("master outlived comparator");

  property p_oc_stop;
    @(posedge clk) disable iff (!rst_n)
      pinS[PIN_SWOC] |=> !master_ff && !slave_ff && !ocN_ff && !faultN_ff;
  endproperty
  a_oc_stop: assert property (p_oc_stop) else $error("overcurrent did not stop drives");

  property p_slave_off;
    @(posedge clk) disable iff (!rst_n) syncFall |=> !slave_ff;
  endproperty
  a_slave_off: assert property (p_slave_off) else $error("slave kept after master fall");

  property p_bridge_excl;
    @(posedge clk) disable iff (!rst_n)
      (brA_ff || brB_ff) |-> !(brA_ff && brB_ff) && $past(inInrush);
  endproperty
  a_bridge_excl: assert property (p_bridge_excl) else $error("bridge drive misuse");

  property p_power_good;
    @(posedge clk) disable iff (!rst_n) $fell(pgN_ff) |-> $past(state_ff) == ST_BURST;
  endproperty
  a_power_good: assert property (p_power_good) else $error("power good at wrong time");

  property p_idle_quiet;
    @(posedge clk) disable iff (!rst_n) (state_ff == ST_IDLE) ##1 (state_ff == ST_IDLE) |->
      !master_ff && !slave_ff && !brA_ff && !brB_ff && pgN_ff;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("drive active before start");

endmodule

// File: verification/ips_power_stage.sv
// Power stage model: board loopbacks, duty comparators and mains square wave.
`timescale 1ns/1ps
module ips_power_stage #(
  parameter int DUTY_CYC  = 120,
  parameter int LINE_HALF = 1500
) (
  // Clock
  input  wire logic clk,
  // From the device
  input  wire logic switchClk,
  input  wire logic masterChannelDrive,
  input  wire logic phaseSetOut,
  // To the device
  output logic      enableIn,
  output logic      syncInput,
  output logic      phaseSetIn,
  output logic      lineZeroCross,
  output logic      dutyComparatorA,
  output logic      dutyComparatorB
);
  int rampCnt = 0;
  int lineCnt = 0;
  assign enableIn   = switchClk;
  assign syncInput  = masterChannelDrive;
  assign phaseSetIn = phaseSetOut;
  initial lineZeroCross = 1'b0;
  // The triangle restarts with the clock wave, so the duty is a fixed count.
  always @(negedge clk) begin
    rampCnt <= switchClk ? rampCnt + 1 : 0;
    dutyComparatorA <= switchClk && rampCnt < DUTY_CYC;
    dutyComparatorB <= switchClk && rampCnt < DUTY_CYC;
    lineCnt <= (lineCnt == LINE_HALF - 1) ? 0 : lineCnt + 1;
    if (lineCnt == LINE_HALF - 1) begin
      lineZeroCross <= ~lineZeroCross;
    end
  end
endmodule

// File: verification/test_ips_sequencer.sv
// Self-checking bench of the interleaved PFC sequencer.
`timescale 1ns/1ps
module test_ips_sequencer import ips_pkg::*;;
  localparam int INR = 8000;
  localparam int GAP = 100;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                startReq = 1'b0;
  logic                swOc = 1'b0;
  logic                inOc = 1'b0;
  logic                measValid = 1'b0;
  ips_meas_t           meas;
  ips_cfg_t            cfg;
  logic                enableIn, syncInput, phaseSetIn, lineZc, dutyA, dutyB;
  logic                swClk, master, psOut, slave, bA, bB, pgN, faultN, ocN, coolN;
  logic [MEAS_W-1:0]   currentRef, rms;
  logic signed [MEAS_W:0] trim;
  int                  failures = 0;
  int                  n_compared = 0;
  int                  waited, t0, seed;
  logic                p1, hiM, hiS;
  time                 tStart;

  ips_sequencer #(.INRUSH_CYCLES(INR), .GAP_CYCLES(GAP)) dut (.clk(clk), .rst_n(rst_n),
    .startReq(startReq), .enableIn(enableIn), .syncInput(syncInput), .phaseSetIn(phaseSetIn),
    .lineZeroCross(lineZc), .dutyComparatorA(dutyA), .dutyComparatorB(dutyB),
    .switchOvercurrentComparator(swOc), .inputOvercurrentComparator(inOc), .meas(meas),
    .measValid(measValid), .cfg(cfg), .switchClk(swClk), .masterChannelDrive(master),
    .phaseSetOut(psOut), .slaveChannelDrive(slave), .bridgeSwitchA(bA), .bridgeSwitchB(bB),
    .powerGoodN(pgN), .faultIndicatorN(faultN), .overcurrentIndicatorN(ocN),
    .coolingReqN(coolN), .currentRef(currentRef), .rmsLineVoltage(rms), .balanceTrim(trim));
  ips_power_stage stage (.clk(clk), .switchClk(swClk), .masterChannelDrive(master),
    .phaseSetOut(psOut), .enableIn(enableIn), .syncInput(syncInput), .phaseSetIn(phaseSetIn),
    .lineZeroCross(lineZc), .dutyComparatorA(dutyA), .dutyComparatorB(dutyB));

  initial forever #12.5 clk = ~clk;

  function automatic logic signed [MEAS_W:0] expTrim(logic [11:0] a, logic [11:0] b);
    return $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction
  function automatic logic [11:0] expRef(int idx);
    return 12'((int'(SOFT_REF) * int'(SINE_LUT[idx])) >> 8);
  endfunction
  function automatic logic [11:0] expRms(logic [11:0] d);
    return d + (d >> 3);
  endfunction
  function automatic logic sigVal(int code);
    case (code)
      0: return ocN;
      1: return faultN;
      2: return pgN;
      3: return coolN;
      4: return slave;
      5: return bA | bB;
      7: return lineZc;
      default: return master;
    endcase
  endfunction
  task automatic wrap_up();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(logic ok, string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask
  // A wait that runs out cannot leave the later checks meaningful, so it ends the run.
  task automatic waitVal(int code, logic v, int bound);
    waited = 0;
    while (sigVal(code) !== v && waited < bound) begin
      @(negedge clk);
      waited++;
    end
    check(sigVal(code) === v, "output level not reached in time");
    if (sigVal(code) !== v) wrap_up();
  endtask
  task automatic sendMeas();
    @(negedge clk);
    measValid = 1'b1;
    @(negedge clk);
    measValid = 1'b0;
    @(negedge clk);
  endtask

  initial begin
    seed = 93;
    cfg = '{12'h800, 12'h780, 12'h820, 12'he00, 12'h100, 12'h100, 12'h400, 24'h100000};
    meas = '{12'h300, 12'h100, 12'h800, 12'h000, 12'h000, 12'h000, 12'h000};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    sendMeas();
    repeat (20) begin
      @(negedge clk);
      check({master, slave, bA, bB, pgN} === 5'b00001, "drive before start");
    end
    repeat (8) begin
      meas.ich0 = 12'($random(seed));
      meas.ich1 = 12'($random(seed));
      sendMeas();
      check(trim === expTrim(meas.ich0, meas.ich1), "balance trim wrong");
    end
    measValid = 1'b1;
    repeat (512) @(negedge clk);
    measValid = 1'b0;
    repeat (3) @(negedge clk);
    check(rms === expRms(12'h200), "line RMS wrong");
    $display("Test measurements done");
    inOc = 1'b1;
    waitVal(0, 1'b0, 8);
    check(faultN === 1'b1, "input overcurrent gave a fault");
    inOc = 1'b0;
    waitVal(0, 1'b1, 8);
    swOc = 1'b1;
    waitVal(1, 1'b0, 8);
    check(ocN === 1'b0, "switch overcurrent not indicated");
    swOc = 1'b0;
    waitVal(1, 1'b1, 8);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) meas.temp = 12'h050;
      else meas.vout = 12'hf00;
      sendMeas();
      waitVal(1, 1'b0, 4);
      meas.temp = 12'h800;
      meas.vout = 12'h000;
      sendMeas();
      waitVal(1, 1'b1, 4);
    end
    meas.vout = 12'h400;
    meas.iout = 12'h400;
    sendMeas();
    repeat (4) @(negedge clk);
    check(coolN === 1'b1, "cooling at threshold");
    meas.vout = 12'h800;
    sendMeas();
    waitVal(3, 1'b0, 4);
    meas.vout = 12'h000;
    meas.iout = 12'h000;
    sendMeas();
    waitVal(3, 1'b1, 4);
    $display("Test protection done");
    startReq = 1'b1;
    tStart = $time;
    waitVal(5, 1'b1, INR);
    check(master === 1'b0, "channel drive during inrush");
    p1 = bA;
    waitVal(5, 1'b0, 900);
    t0 = waited;
    waitVal(5, 1'b1, 1600);
    check(t0 + waited inside {[1295:1305]} && bA !== p1, "bridge step wrong");
    waitVal(6, 1'b1, INR + GAP + 1000);
    check(($time - tStart) / 25 >= INR + GAP, "soft start too early");
    sendMeas();
    waitVal(7, 1'b0, 1600);
    waitVal(7, 1'b1, 1600);
    repeat (8) @(negedge clk);
    check(currentRef === expRef(0), "soft current reference wrong");
    repeat (1200) @(negedge clk);
    waitVal(6, 1'b0, 400);
    waitVal(6, 1'b1, 400);
    check(swClk === 1'b1, "master began outside clock high half");
    waitVal(4, 1'b0, 400);
    t0 = waited;
    waitVal(4, 1'b1, 400);
    check(psOut === 1'b1, "set pulse absent at slave turn-on");
    check(t0 + waited inside {[195:225]}, "slave phase wrong");
    waitVal(6, 1'b1, 400);
    waitVal(6, 1'b0, 400);
    waitVal(4, 1'b0, 8);
    meas.vout = 12'h800;
    sendMeas();
    waitVal(2, 1'b0, 6);
    meas.vout = 12'h830;
    sendMeas();
    repeat (10) @(negedge clk);
    hiM = 1'b0;
    repeat (800) @(negedge clk) hiM |= master;
    check(hiM === 1'b0, "burst drove above upper level");
    meas.vout = 12'h700;
    sendMeas();
    waitVal(6, 1'b1, 500);
    meas.iout = 12'h200;
    sendMeas();
    repeat (10) @(negedge clk);
    hiM = 1'b0;
    hiS = 1'b0;
    repeat (800) @(negedge clk) {hiM, hiS} |= {master, slave};
    check(hiM === 1'b1 && hiS === 1'b0 && pgN === 1'b0, "load mode wrong");
    meas.iout = 12'h500;
    sendMeas();
    waitVal(4, 1'b1, 1000);
    swOc = 1'b1;
    waitVal(1, 1'b0, 8);
    repeat (2) @(negedge clk);
    check({master, slave} === 2'b00, "drives not stopped");
    swOc = 1'b0;
    $display("Test sequence done");
    wrap_up();
  end
endmodule
